// ### hsibc_cfg.svh
// Purpose: offsets, field positions and reset values for the count write-back
// Assumes: word-aligned AXI4-Lite register map
// Notes:   definitions only
`ifndef HSIBC_CFG_SVH
`define HSIBC_CFG_SVH

// register word indices; byte address is four times the index
`define HSIBC_IDX_UFRAME   4'h0
`define HSIBC_IDX_SCHED    4'h1
`define HSIBC_IDX_DESC5    4'h2
`define HSIBC_IDX_DESC6    4'h3
`define HSIBC_IDX_DESC7    4'h4
`define HSIBC_IDX_STATUS   4'h5

// frame number field inside the byte of the microframe register, word index 0
`define HSIBC_FRAME_HI     7
`define HSIBC_FRAME_LO     3

`define HSIBC_UFRAME_RST   8'h00
`define HSIBC_SCHED_RST    8'h00
`define HSIBC_COUNT_RST    12'h000

`define HSIBC_RESP_OKAY    2'h0
`define HSIBC_RESP_SLVERR  2'h2

`endif

// ### hsibc_ep_model.sv
// Purpose: interrupt IN endpoint answering each accepted microframe
// Assumes: go is a one-cycle pulse
// Notes:   count is garbage outside the done cycle
`timescale 1ns/10ps
`default_nettype none
module hsibc_ep_model (
   input  wire logic        aclk,
   input  wire logic        go,
   input  wire logic [2:0]  dly,
   input  wire logic [11:0] cnt_in,
   output var  logic        done,
   output var  logic [11:0] cnt
);
   logic [3:0]  t      = 4'h0;
   logic        done_q = 1'b0;
   logic [11:0] cnt_q  = 12'hFFF;
   assign done = done_q;
   assign cnt  = cnt_q;
   always @(posedge aclk) begin
      done_q <= !go && t == 4'h1;
      cnt_q  <= (!go && t == 4'h1) ? cnt_in : ~cnt_q;
      if (go) t <= {1'b0, dly} + 4'h1;
      else if (t != 4'h0) t <= t - 4'h1;
   end
endmodule : hsibc_ep_model
`default_nettype wire

// ### hsibc_pkg.sv
// Purpose: types shared by the count write-back block
// Assumes: hsibc_cfg.svh constants
// Notes:   state of each module is one packed struct
`default_nettype none
package hsibc_pkg;

   typedef enum logic [0:0] {
      HSIBC_IDLE,
      HSIBC_BUSY
   } hsibc_state_e;

   typedef logic [11:0] hsibc_count_t;

   typedef struct packed {
      hsibc_state_e st;
      logic [2:0]   cur_uf;
      logic [7:0]   mask;
      logic [7:0]   uf_field;
      logic         go;
      logic         aw_hold;
      logic [3:0]   aw_idx;
      logic         w_hold;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
   } hsibc_main_s;

   typedef struct packed {
      hsibc_count_t [7:0] cnt;
   } hsibc_store_s;

endpackage : hsibc_pkg
`default_nettype wire

// ### hsibc_store.sv
// Purpose: holds eight microframe counts and packs them into descriptor words
// Assumes: writes come only from the control module
// Notes:   unwritten counts keep their value
`timescale 1ns/10ps
`default_nettype none
`include "hsibc_cfg.svh"
module hsibc_store
   import hsibc_pkg::*;
(
   input  wire logic   aclk,
   input  wire logic   aresetn,
   hsibc_store_if.st   sif
);

   hsibc_store_s state_reg;
   hsibc_store_s state_next;

   always_comb begin
      state_next = state_reg;
      if (sif.wr_en) begin
         state_next.cnt[sif.wr_idx] = sif.wr_cnt;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '{cnt: {8{`HSIBC_COUNT_RST}}};
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // word 5 upper half
   assign sif.dw5_hi = {state_reg.cnt[2][7:0],
                        state_reg.cnt[1],
                        state_reg.cnt[0]};
   // word 6 lower half
   assign sif.dw6_lo = {state_reg.cnt[5][3:0],
                        state_reg.cnt[4],
                        state_reg.cnt[3],
                        state_reg.cnt[2][11:8]};
   // word 7 upper half
   assign sif.dw7_hi = {state_reg.cnt[7],
                        state_reg.cnt[6],
                        state_reg.cnt[5][11:4]};

endmodule : hsibc_store
`default_nettype wire

// ### hsibc_store_if.sv
// Purpose: carrier between the write-back control and the count store
// Assumes: one clock
// Notes:   descriptor words are packed by the store
`timescale 1ns/10ps
`default_nettype none
interface hsibc_store_if;
   logic        wr_en;
   logic [2:0]  wr_idx;
   logic [11:0] wr_cnt;
   logic [31:0] dw5_hi;
   logic [31:0] dw6_lo;
   logic [31:0] dw7_hi;

   modport ctl (output wr_en, output wr_idx, output wr_cnt,
                input dw5_hi, input dw6_lo, input dw7_hi);
   modport st  (input wr_en, input wr_idx, input wr_cnt,
                output dw5_hi, output dw6_lo, output dw7_hi);
endinterface : hsibc_store_if
`default_nettype wire

// ### hsibc_wb_sva.sv
// Purpose: port checker for the count write-back block
// Assumes: bound to hsibc_writeback, one clock
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
module hsibc_wb_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        uframe_start,
   input wire logic [2:0]  uframe_num,
   input wire logic        in_done,
   input wire logic        uframe_go,
   input wire logic        xfer_busy,
   input wire logic [7:0]  uframe_schedule_mask,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic hit;
   logic [7:0] m;
   assign hit = uframe_schedule_mask[uframe_num];
   assign m = uframe_schedule_mask;
   chk_go_cause: assert property (uframe_go |-> $past(uframe_start)
      && $past(hit) && !$past(xfer_busy)) else $error("go not caused");
   chk_go_pulse: assert property (
      uframe_go |-> xfer_busy ##1 !uframe_go) else $error("go not a pulse");
   chk_mask_clear: assert property (|($past(m) & ~m) |-> $past(in_done)
      && $past(xfer_busy)) else $error("mask bit cleared early");
   chk_done_idle: assert property (xfer_busy && in_done |=> !xfer_busy)
      else $error("busy after done");
   chk_busy_hold: assert property (xfer_busy && !in_done |=> xfer_busy)
      else $error("busy dropped");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer held");
   cov_go: cover property (uframe_go);
   cov_done: cover property (xfer_busy && in_done);
   cov_refused: cover property (uframe_start && !hit);
endmodule : hsibc_wb_sva
`default_nettype wire

// ### hsibc_writeback.sv
// Purpose: interrupt IN received-byte-count write-back with register access
// Assumes: transaction strobes come from logic on aclk
// Notes:   one microframe transaction in flight at a time
`timescale 1ns/10ps
`default_nettype none
`include "hsibc_cfg.svh"
module hsibc_writeback
   import hsibc_pkg::*;
#(
   parameter int ADDR_W  = 8,
   parameter int COUNT_W = 12,
   parameter int NUM_UF  = 8
)(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              uframe_start,
   input  wire logic [2:0]        uframe_num,
   input  wire logic [4:0]        bus_frame_num,
   input  wire logic              in_done,
   input  wire logic [11:0]       in_byte_count,
   output logic                   uframe_go,
   output logic                   xfer_busy,
   output logic [7:0]             uframe_schedule_mask
);

   if (COUNT_W != 12) begin : g_check_count
      $error("hsibc_writeback: count width must be 12");
   end
   if (NUM_UF != 8) begin : g_check_uf
      $error("hsibc_writeback: eight microframes per frame only");
   end
   if (ADDR_W < 6) begin : g_check_addr
      $error("hsibc_writeback: address needs bits 5 to 2");
   end

   hsibc_main_s   state_reg;
   hsibc_main_s   state_next;
   hsibc_store_if sif();

   hsibc_store u_store (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sif     (sif)
   );

   logic       frame_ok;
   logic       sched_hit;
   logic [7:0] hw_clr;
   logic [7:0] sw_set;
   logic [3:0] ar_idx;
   logic       uf_accept;
   logic       uf_finish;
   logic       wr_fire;
   logic       rd_fire;

   ////////////////////////////////////////////////////////////////////////////
   // schedule check and frame match
   assign frame_ok  = state_reg.uf_field[`HSIBC_FRAME_HI:`HSIBC_FRAME_LO]
                      == bus_frame_num;
   assign sched_hit = state_reg.mask[uframe_num] && frame_ok;
   assign ar_idx    = s_axi_araddr[5:2];
   assign uf_accept = (state_reg.st == HSIBC_IDLE) && uframe_start
                      && sched_hit;
   assign uf_finish = (state_reg.st == HSIBC_BUSY) && in_done;
   assign wr_fire   = state_reg.aw_hold && state_reg.w_hold
                      && !state_reg.bvalid;
   assign rd_fire   = s_axi_arvalid && !state_reg.rvalid;

   ////////////////////////////////////////////////////////////////////////////
   // bus readies
   assign s_axi_awready = !state_reg.aw_hold;
   assign s_axi_wready  = !state_reg.w_hold;
   assign s_axi_arready = !state_reg.rvalid;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_next = state_reg;
      hw_clr     = 8'h00;
      sw_set     = 8'h00;
      sif.wr_en  = 1'b0;
      sif.wr_idx = state_reg.cur_uf;
      sif.wr_cnt = in_byte_count;
      state_next.go = 1'b0;

      // transaction sequencing
      unique case (state_reg.st)
         HSIBC_IDLE: begin
            if (uf_accept) begin
               state_next.cur_uf = uframe_num;
               state_next.go     = 1'b1;
               state_next.st     = HSIBC_BUSY;
            end
         end
         HSIBC_BUSY: begin
            if (uf_finish) begin
               sif.wr_en = 1'b1;
               hw_clr[state_reg.cur_uf] = 1'b1;
               state_next.st = HSIBC_IDLE;
            end
         end
      endcase

      // write channel capture
      if (s_axi_awvalid && !state_reg.aw_hold) begin
         state_next.aw_hold = 1'b1;
         state_next.aw_idx  = s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && !state_reg.w_hold) begin
         state_next.w_hold = 1'b1;
         state_next.wdata  = s_axi_wdata;
         state_next.wstrb  = s_axi_wstrb;
      end
      if (state_reg.bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end

      // register write once address and data are both held
      if (wr_fire) begin
         state_next.aw_hold = 1'b0;
         state_next.w_hold  = 1'b0;
         state_next.bvalid  = 1'b1;
         state_next.bresp   = `HSIBC_RESP_OKAY;
         unique case (state_reg.aw_idx)
            `HSIBC_IDX_UFRAME: begin
               if (state_reg.wstrb[0]) begin
                  state_next.uf_field = state_reg.wdata[7:0];
               end
            end
            `HSIBC_IDX_SCHED: begin
               if (state_reg.wstrb[0]) begin
                  sw_set = state_reg.wdata[7:0];
               end
            end
            `HSIBC_IDX_DESC5, `HSIBC_IDX_DESC6,
            `HSIBC_IDX_DESC7, `HSIBC_IDX_STATUS: begin
               // read-only, write ignored
            end
            default: begin
               state_next.bresp = `HSIBC_RESP_SLVERR;
            end
         endcase
      end

      // set wins over the hardware clear
      state_next.mask = (state_reg.mask & ~hw_clr) | sw_set;

      // read channel
      if (state_reg.rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end
      if (rd_fire) begin
         state_next.rvalid = 1'b1;
         state_next.rresp  = `HSIBC_RESP_OKAY;
         unique case (ar_idx)
            `HSIBC_IDX_UFRAME: state_next.rdata = {24'h000000,
                                                   state_reg.uf_field};
            `HSIBC_IDX_SCHED:  state_next.rdata = {24'h000000,
                                                   state_reg.mask};
            `HSIBC_IDX_DESC5:  state_next.rdata = sif.dw5_hi;
            `HSIBC_IDX_DESC6:  state_next.rdata = sif.dw6_lo;
            `HSIBC_IDX_DESC7:  state_next.rdata = sif.dw7_hi;
            `HSIBC_IDX_STATUS: state_next.rdata = {28'h0000000,
                                 state_reg.cur_uf,
                                 state_reg.st == HSIBC_BUSY};
            default: begin
               state_next.rdata = 32'h00000000;
               state_next.rresp = `HSIBC_RESP_SLVERR;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg          <= '0;
         state_reg.st       <= HSIBC_IDLE;
         state_reg.mask     <= `HSIBC_SCHED_RST;
         state_reg.uf_field <= `HSIBC_UFRAME_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign s_axi_bvalid         = state_reg.bvalid;
   assign s_axi_bresp          = state_reg.bresp;
   assign s_axi_rvalid         = state_reg.rvalid;
   assign s_axi_rdata          = state_reg.rdata;
   assign s_axi_rresp          = state_reg.rresp;
   assign uframe_go            = state_reg.go;
   assign xfer_busy            = state_reg.st == HSIBC_BUSY;
   assign uframe_schedule_mask = state_reg.mask;

endmodule : hsibc_writeback
`default_nettype wire

// ### testbench.sv
// Purpose: register and microframe sequences for the write-back block
// Assumes: AXI4-Lite master, endpoint model on the link side
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
`include "hsibc_cfg.svh"
module testbench;
   import hsibc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, start = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, mk = 8'h6D;
   logic [31:0] wdata = 32'h0, rv;
   logic [2:0] unum = 3'h0, dly = 3'h0;
   logic [4:0] bfn = 5'h00;
   logic [11:0] cnt_in = 12'h000, c [8];
   logic [1:0] rs;
   wire logic awready, wready, bvalid, arready, rvalid, go, busy, done;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [11:0] cnt;
   wire logic [7:0] mask;
   int bad_count = 0, num_checks = 0;
   always #25 aclk = ~aclk;
   hsibc_writeback DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .uframe_start(start), .uframe_num(unum),
      .bus_frame_num(bfn), .in_done(done), .in_byte_count(cnt),
      .uframe_go(go), .xfer_busy(busy), .uframe_schedule_mask(mask));
   hsibc_ep_model u_ep (.aclk(aclk), .go(go), .dly(dly), .cnt_in(cnt_in),
      .done(done), .cnt(cnt));
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic tmo;
      bad_count++;
      $display("CHECK FAILED %0t wait ran out", $time);
      wrap_up;
   endtask : tmo
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      rs = bresp;
      bready <= 1'b0;
      if (n == 100) tmo;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rv = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n == 100) tmo;
   endtask : rd
   task automatic run_uf(input logic [2:0] u, input logic e);
      int n;
      @(posedge aclk);
      unum <= u;
      cnt_in <= c[u];
      dly <= u % 3'h3;
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
      @(posedge aclk);
      chk({31'h0, go}, {31'h0, e});
      chk({31'h0, busy}, {31'h0, e});
      for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge aclk);
      if (n == 40) tmo;
   endtask : run_uf
   ////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 8; i++) c[i] = 12'h5A0 + 12'h111 * 12'(i);
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h04);
      chk(rv, 32'h0);
      wr(8'h00, 32'h28);
      rd(8'h00);
      chk(rv, 32'h28);
      bfn <= 5'h05;
      wr(8'h04, {24'h0, mk});
      rd(8'h04);
      chk(rv, {24'h0, mk});
      for (int i = 0; i < 8; i++) run_uf(3'(i), mk[i]);
      rd(8'h04);
      chk(rv, 32'h0);
      rd(8'h08);
      chk(rv, {c[2][7:0], 12'h000, c[0]});
      rd(8'h0C);
      chk(rv, {c[5][3:0], 12'h000, c[3], c[2][11:8]});
      chk({30'h0, rs}, {30'h0, `HSIBC_RESP_OKAY});
      wr(8'h04, 32'h80);
      chk({24'h0, mask}, 32'h80);
      bfn <= 5'h06;
      run_uf(3'h7, 1'b0);
      rd(8'h10);
      chk(rv, {12'h000, c[6], c[5][11:4]});
      bfn <= 5'h05;
      run_uf(3'h7, 1'b1);
      rd(8'h10);
      chk(rv, {c[7], c[6], c[5][11:4]});
      chk({24'h0, mask}, 32'h0);
      rd(8'h14);
      chk(rv, 32'h0000000E);
      wr(8'h08, 32'hFFFFFFFF);
      chk({30'h0, rs}, {30'h0, `HSIBC_RESP_OKAY});
      rd(8'h08);
      chk(rv, {c[2][7:0], 12'h000, c[0]});
      rd(8'h3C);
      chk({30'h0, rs}, {30'h0, `HSIBC_RESP_SLVERR});
      chk(rv, 32'h0);
      wr(8'h3C, 32'h0);
      chk({30'h0, rs}, {30'h0, `HSIBC_RESP_SLVERR});
      wrap_up;
   end
endmodule : testbench
bind hsibc_writeback hsibc_wb_sva u_sva (.aclk(aclk), .aresetn(aresetn),
   .uframe_start(uframe_start), .uframe_num(uframe_num), .in_done(in_done),
   .uframe_go(uframe_go), .xfer_busy(xfer_busy),
   .uframe_schedule_mask(uframe_schedule_mask),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata));
`default_nettype wire
